// File: rtl/hbp_consts.svh
// Constants shared by both ends of the host bus port
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH

// ============================================================
// Widths
`define HBP_ADDR_W        32
`define HBP_DATA_W        32
`define HBP_IRQ_W         8

// ============================================================
// Timing counts
// Least gap between releasing one slave select and asserting the other
`define HBP_SEL_GAP_CLKS  2
// Device access timer load; the device keeps its own buffer access this many cycles plus one
`define HBP_OWN_ACC_CLKS  4'h2

// ============================================================
// Reset values
`define HBP_IRQ_MASK_RST  8'h00
`define HBP_BUS_STYLE_NAT 1'b0

`endif

// File: rtl/hbp_pkg.sv
// Types shared by both ends of the host bus port
package hbp_pkg;

    // ============================================================
    // Master cycle states, Gray coded along request-grant-strobe-data
    typedef enum logic [2:0] {
        HBP_M_IDLE  = 3'b000,
        HBP_M_REQ   = 3'b001,
        HBP_M_ADDR  = 3'b011,
        HBP_M_DATA  = 3'b010,
        HBP_M_DONE  = 3'b110
    } hbp_mst_e;

    // ============================================================
    // Buffer memory arbiter owner
    typedef enum logic [1:0] {
        HBP_OWN_NONE = 2'b00,
        HBP_OWN_HOST = 2'b01,
        HBP_OWN_DEV  = 2'b11
    } hbp_own_e;

    // ============================================================
    // Host side slave access states
    typedef enum logic [1:0] {
        HBP_H_IDLE = 2'b00,
        HBP_H_WAIT = 2'b01,
        HBP_H_HOLD = 2'b11,
        HBP_H_GAP  = 2'b10
    } hbp_hst_e;

endpackage : hbp_pkg

// File: rtl/hbp_if.sv
// Interface joining the device end and the host end of the port
`timescale 1ns/1ns
`include "hbp_consts.svh"

interface hbp_if;
    // ============================================================
    // Slave access signals: selects driven by the host, acknowledge by the device
    logic                     chip_select_n;
    logic                     shared_mem_request_n;
    logic                     slave_access_ack_n;
    // ============================================================
    // Master side signals
    logic                     bus_style_select;
    logic                     bus_request;
    logic                     bus_grant_in;
    logic                     addr_valid_strobe;
    logic                     transfer_direction;
    logic                     data_phase_strobe_n;
    logic                     wait_ready_in;
    logic                     master_oe;
    logic [`HBP_ADDR_W-1:0]   master_addr;
    logic [`HBP_DATA_W-1:0]   master_wdata;
    logic [`HBP_DATA_W-1:0]   master_rdata;
    logic                     irq_out;

    // Documented device end
    modport dev (
        input  chip_select_n, shared_mem_request_n, bus_style_select,
        input  bus_grant_in, wait_ready_in, master_rdata,
        output slave_access_ack_n, bus_request, addr_valid_strobe,
        output transfer_direction, data_phase_strobe_n, master_oe,
        output master_addr, master_wdata, irq_out
    );

    // System / host end
    modport host (
        output chip_select_n, shared_mem_request_n, bus_style_select,
        output bus_grant_in, wait_ready_in, master_rdata,
        input  slave_access_ack_n, bus_request, addr_valid_strobe,
        input  transfer_direction, data_phase_strobe_n, master_oe,
        input  master_addr, master_wdata, irq_out
    );
endinterface : hbp_if

// File: rtl/hbp_dev.sv
// Device end: bus master cycle, slave acknowledge with arbiter, interrupt
`timescale 1ns/1ns
`include "hbp_consts.svh"

module hbp_dev (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    // Link to the host
    hbp_if.dev                            bus,
    // Master cycle requests from the controller core
    input  wire logic                     mst_start,
    input  wire logic                     mst_write,
    input  wire logic [`HBP_ADDR_W-1:0]   mst_addr,
    input  wire logic [`HBP_DATA_W-1:0]   mst_wdata,
    output logic                          mst_done,
    output logic [`HBP_DATA_W-1:0]        mst_rdata,
    // Own buffer memory access request
    input  wire logic                     own_mem_req,
    output logic                          own_mem_gnt,
    // Register slave readiness
    input  wire logic                     regs_ready,
    // Interrupt status sources and mask
    input  wire logic [`HBP_IRQ_W-1:0]    irq_set,
    input  wire logic [`HBP_IRQ_W-1:0]    irq_clr,
    input  wire logic [`HBP_IRQ_W-1:0]    irq_mask,
    output logic [`HBP_IRQ_W-1:0]         irq_status
);

    // ============================================================
    // Master cycle state
    hbp_pkg::hbp_mst_e          mst_q, mst_d;            // Master state
    logic                       req_q, req_d;            // Bus request pin
    logic                       ads_q, ads_d;            // Address strobe pin
    logic                       dir_q, dir_d;            // Direction pin
    logic                       ds_n_q, ds_n_d;          // Data strobe pin
    logic                       oe_q, oe_d;              // Master drive enable
    logic [`HBP_ADDR_W-1:0]     addr_q, addr_d;          // Held cycle address
    logic [`HBP_DATA_W-1:0]     wdat_q, wdat_d;          // Held write data
    logic [`HBP_DATA_W-1:0]     rdat_q, rdat_d;          // Captured read data
    logic                       done_q, done_d;          // Cycle finished pulse
    logic                       nat_mode;                // Bus style zero

    assign nat_mode = (bus.bus_style_select == `HBP_BUS_STYLE_NAT);

    // Next values for the master cycle
    always_comb
    begin
        mst_d  = mst_q;
        req_d  = req_q;
        ads_d  = ads_q;
        dir_d  = dir_q;
        ds_n_d = ds_n_q;
        oe_d   = oe_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        done_d = 1'b0;
        case (mst_q)
            hbp_pkg::HBP_M_IDLE:
            begin
                // Only the bus style zero pinout is handled here
                if (mst_start && nat_mode)
                begin
                    req_d  = 1'b1;
                    addr_d = mst_addr;
                    wdat_d = mst_wdata;
                    dir_d  = mst_write;
                    mst_d  = hbp_pkg::HBP_M_REQ;
                end
            end
            hbp_pkg::HBP_M_REQ:
            begin
                // Wait for grant; drive enable and address strobe stay off before it
                if (bus.bus_grant_in)
                begin
                    oe_d  = 1'b1;
                    ads_d = 1'b0;
                    mst_d = hbp_pkg::HBP_M_ADDR;
                end
            end
            hbp_pkg::HBP_M_ADDR:
            begin
                // Strobe rises: address and direction valid now
                ads_d  = 1'b1;
                ds_n_d = 1'b0;
                mst_d  = hbp_pkg::HBP_M_DATA;
            end
            hbp_pkg::HBP_M_DATA:
            begin
                // Ready high inserts waits, low ends the cycle
                if (!bus.wait_ready_in)
                begin
                    ds_n_d = 1'b1;
                    rdat_d = dir_q ? rdat_q : bus.master_rdata;
                    mst_d  = hbp_pkg::HBP_M_DONE;
                end
            end
            hbp_pkg::HBP_M_DONE:
            begin
                // Release bus and drop request, no activity left
                oe_d   = 1'b0;
                dir_d  = 1'b0;
                req_d  = 1'b0;
                done_d = 1'b1;
                mst_d  = hbp_pkg::HBP_M_IDLE;
            end
            default:
            begin
                mst_d = hbp_pkg::HBP_M_IDLE;
            end
        endcase
    end

    // Register the master cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mst_q  <= hbp_pkg::HBP_M_IDLE;
            req_q  <= 1'b0;
            ads_q  <= 1'b1;
            dir_q  <= 1'b0;
            ds_n_q <= 1'b1;
            oe_q   <= 1'b0;
            addr_q <= '0;
            wdat_q <= '0;
            rdat_q <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            mst_q  <= mst_d;
            req_q  <= req_d;
            ads_q  <= ads_d;
            dir_q  <= dir_d;
            ds_n_q <= ds_n_d;
            oe_q   <= oe_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            done_q <= done_d;
        end
    end

    // ============================================================
    // Buffer arbiter and slave acknowledge
    hbp_pkg::hbp_own_e          own_q, own_d;            // Current memory owner
    logic [3:0]                 dcnt_q, dcnt_d;          // Device access timer
    logic                       ack_n_q, ack_n_d;        // Acknowledge pin

    // Next owner; host waits while the device holds memory
    always_comb
    begin
        own_d   = own_q;
        dcnt_d  = dcnt_q;
        ack_n_d = 1'b1;
        case (own_q)
            hbp_pkg::HBP_OWN_NONE:
            begin
                // Host first: its wait is visible to software timing
                if (!bus.shared_mem_request_n)
                    own_d = hbp_pkg::HBP_OWN_HOST;
                else if (own_mem_req)
                begin
                    own_d  = hbp_pkg::HBP_OWN_DEV;
                    dcnt_d = `HBP_OWN_ACC_CLKS;
                end
            end
            hbp_pkg::HBP_OWN_HOST:
            begin
                // Memory is ours to give until the request drops
                if (bus.shared_mem_request_n)
                    own_d = hbp_pkg::HBP_OWN_NONE;
                else
                    ack_n_d = 1'b0;
            end
            hbp_pkg::HBP_OWN_DEV:
            begin
                if (dcnt_q == 4'h0)
                    own_d = hbp_pkg::HBP_OWN_NONE;
                else
                    dcnt_d = dcnt_q - 4'h1;
            end
            default:
            begin
                own_d = hbp_pkg::HBP_OWN_NONE;
            end
        endcase
        // Register access answers independently; host keeps the two apart
        if (!bus.chip_select_n && regs_ready)
            ack_n_d = 1'b0;
    end

    // Register arbiter state
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            own_q   <= hbp_pkg::HBP_OWN_NONE;
            dcnt_q  <= 4'h0;
            ack_n_q <= 1'b1;
        end
        else
        begin
            own_q   <= own_d;
            dcnt_q  <= dcnt_d;
            ack_n_q <= ack_n_d;
        end
    end

    // ============================================================
    // Interrupt status and output level
    logic [`HBP_IRQ_W-1:0]      ist_q, ist_d;            // Sticky status
    logic                       irq_q, irq_d;            // Interrupt pin

    // Set wins over clear so no event is lost
    always_comb
    begin
        ist_d = (ist_q & ~irq_clr) | irq_set;
        irq_d = nat_mode && |(ist_d & irq_mask);
    end

    // Register interrupt state
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ist_q <= `HBP_IRQ_MASK_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d;
            irq_q <= irq_d;
        end
    end

    // ============================================================
    // Outputs, all from flip-flops
    assign bus.bus_request         = req_q;
    assign bus.addr_valid_strobe   = ads_q;
    assign bus.transfer_direction  = dir_q;
    assign bus.data_phase_strobe_n = ds_n_q;
    assign bus.master_oe           = oe_q;
    assign bus.master_addr         = addr_q;
    assign bus.master_wdata        = wdat_q;
    assign bus.slave_access_ack_n  = ack_n_q;
    assign bus.irq_out             = irq_q;
    assign mst_done                = done_q;
    assign mst_rdata               = rdat_q;
    assign own_mem_gnt             = own_q[1];       // Only the device owner code has bit 1 set
    assign irq_status              = ist_q;

endmodule : hbp_dev

// File: rtl/hbp_host.sv
// Host end: slave selects with spacing, bus grant, ready and read data
`timescale 1ns/1ns
`include "hbp_consts.svh"

module hbp_host (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    // Link to the device
    hbp_if.host                           bus,
    // User requests
    input  wire logic                     usr_style,
    input  wire logic                     usr_reg_req,
    input  wire logic                     usr_mem_req,
    input  wire logic                     usr_grant_ok,
    input  wire logic                     usr_ready,
    input  wire logic [`HBP_DATA_W-1:0]   usr_rdata,
    output logic                          usr_acc_done,
    output logic                          usr_busy,
    output logic                          usr_irq
);

    // ============================================================
    // Slave access sequencer
    hbp_pkg::hbp_hst_e  st_q, st_d;        // Sequencer state
    logic               cs_n_q, cs_n_d;    // Chip select pin
    logic               mr_n_q, mr_n_d;    // Memory request pin
    logic [1:0]         gap_q, gap_d;      // Spacing counter
    logic               dn_q, dn_d;        // Access done pulse
    logic               gnt_q, gnt_d;      // Bus grant pin
    logic               irq_q;             // Interrupt seen

    // One select at a time, spaced by the gap
    always_comb
    begin
        st_d   = st_q;
        cs_n_d = cs_n_q;
        mr_n_d = mr_n_q;
        gap_d  = gap_q;
        dn_d   = 1'b0;
        case (st_q)
            hbp_pkg::HBP_H_IDLE:
            begin
                // Register access preferred over memory
                if (usr_reg_req)
                begin
                    cs_n_d = 1'b0;
                    st_d   = hbp_pkg::HBP_H_WAIT;
                end
                else if (usr_mem_req)
                begin
                    mr_n_d = 1'b0;
                    st_d   = hbp_pkg::HBP_H_WAIT;
                end
            end
            hbp_pkg::HBP_H_WAIT:
            begin
                // Acknowledge would also open the system drivers
                if (!bus.slave_access_ack_n)
                    st_d = hbp_pkg::HBP_H_HOLD;
            end
            hbp_pkg::HBP_H_HOLD:
            begin
                cs_n_d = 1'b1;
                mr_n_d = 1'b1;
                dn_d   = 1'b1;
                gap_d  = 2'(`HBP_SEL_GAP_CLKS);
                st_d   = hbp_pkg::HBP_H_GAP;
            end
            hbp_pkg::HBP_H_GAP:
            begin
                // Three idle clocks before the next select: two here, one in idle
                if (gap_q == 2'h1)
                    st_d = hbp_pkg::HBP_H_IDLE;
                gap_d = gap_q - 2'h1;
            end
            default:
            begin
                st_d = hbp_pkg::HBP_H_IDLE;
            end
        endcase
        // Grant follows the device request when the user allows
        gnt_d = bus.bus_request && usr_grant_ok;
    end

    // Register sequencer
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_q   <= hbp_pkg::HBP_H_IDLE;
            cs_n_q <= 1'b1;
            mr_n_q <= 1'b1;
            gap_q  <= 2'h0;
            dn_q   <= 1'b0;
            gnt_q  <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            cs_n_q <= cs_n_d;
            mr_n_q <= mr_n_d;
            gap_q  <= gap_d;
            dn_q   <= dn_d;
            gnt_q  <= gnt_d;
            irq_q  <= bus.irq_out;
        end
    end

    // ============================================================
    // Outputs; ready high holds waits, low ends device cycle
    assign bus.chip_select_n        = cs_n_q;
    assign bus.shared_mem_request_n = mr_n_q;
    assign bus.bus_grant_in         = gnt_q;
    assign bus.bus_style_select     = usr_style;
    assign bus.wait_ready_in        = !usr_ready;
    assign bus.master_rdata         = usr_rdata;
    assign usr_acc_done             = dn_q;
    assign usr_busy                 = (st_q != hbp_pkg::HBP_H_IDLE);
    assign usr_irq                  = irq_q;

endmodule : hbp_host

// File: tb/hbp_link_asserts.sv
// Concurrent checks on the wires between the device end and the host end
`timescale 1ns/1ns
`include "hbp_consts.svh"

module hbp_link_asserts (
    // Clock and reset
    input wire logic                   ref_clk,
    input wire logic                   rst,
    // Slave selects and acknowledge
    input wire logic                   chip_select_n,
    input wire logic                   shared_mem_request_n,
    input wire logic                   slave_access_ack_n,
    // Master cycle wires
    input wire logic                   bus_style_select,
    input wire logic                   bus_request,
    input wire logic                   bus_grant_in,
    input wire logic                   addr_valid_strobe,
    input wire logic                   transfer_direction,
    input wire logic                   data_phase_strobe_n,
    input wire logic                   wait_ready_in,
    input wire logic                   master_oe,
    input wire logic [`HBP_ADDR_W-1:0] master_addr,
    // Interrupt
    input wire logic                   irq_out
);
    // ============================================================
    // One clock domain, so one default clocking and disable
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_no_both_selects: assert property (chip_select_n || shared_mem_request_n)
        else $error("select and memory request low together");
    a_gap_after_sel: assert property ($rose(chip_select_n) |-> shared_mem_request_n [*2])
        else $error("memory request too soon after select");
    a_gap_after_mem: assert property ($rose(shared_mem_request_n) |-> chip_select_n [*2])
        else $error("select too soon after memory request");
    a_ack_has_cause: assert property (!slave_access_ack_n |->
        (!$past(chip_select_n) || !$past(shared_mem_request_n)))
        else $error("acknowledge without a select");
    a_mem_ack_bound: assert property ($fell(shared_mem_request_n) |->
        ##[1:6] !slave_access_ack_n)
        else $error("memory acknowledge late");
    a_strobe_after_grant: assert property ($fell(addr_valid_strobe) |->
        $past(bus_grant_in) && bus_request && master_oe)
        else $error("address strobe without grant");
    a_strobe_one_cycle: assert property ($fell(addr_valid_strobe) |=>
        addr_valid_strobe && !data_phase_strobe_n)
        else $error("strobe not followed by data phase");
    a_addr_dir_held: assert property (!data_phase_strobe_n |->
        $stable(master_addr) && $stable(transfer_direction))
        else $error("address or direction moved in data phase");
    a_ready_ends: assert property (!data_phase_strobe_n && !wait_ready_in |=>
        data_phase_strobe_n)
        else $error("data phase not ended by ready");
    a_ready_waits: assert property (!data_phase_strobe_n && wait_ready_in |=>
        !data_phase_strobe_n)
        else $error("wait state not honoured");
    a_oe_needs_req: assert property (master_oe |-> bus_request)
        else $error("driving bus without request");
    a_style_quiet: assert property (bus_style_select |=> !irq_out)
        else $error("interrupt in other bus style");
endmodule : hbp_link_asserts

// File: tb/host_bus_master_slave_port_test.sv
// Self-checking bench with both ends of the host bus port facing each other
`timescale 1ns/1ns
`include "hbp_consts.svh"

module host_bus_master_slave_port_test;
    // ============================================================
    // Clock, reset and inputs of both ends
    logic                   ref_clk      = 1'h0;
    logic                   rst          = 1'h1;
    logic                   mst_start    = 1'h0;
    logic                   mst_write    = 1'h0;
    logic [`HBP_ADDR_W-1:0] mst_addr     = 32'h0000_0000;
    logic [`HBP_DATA_W-1:0] mst_wdata    = 32'h0000_0000;
    logic                   own_mem_req  = 1'h0;
    logic                   regs_ready   = 1'h1;
    logic [`HBP_IRQ_W-1:0]  irq_set      = 8'h00;
    logic [`HBP_IRQ_W-1:0]  irq_clr      = 8'h00;
    logic [`HBP_IRQ_W-1:0]  irq_mask     = 8'h00;
    logic                   usr_reg_req  = 1'h0;
    logic                   usr_mem_req  = 1'h0;
    logic                   usr_grant_ok = 1'h1;
    logic                   usr_style    = 1'h0;
    logic                   usr_ready    = 1'h1;
    logic [`HBP_DATA_W-1:0] usr_rdata    = 32'h0000_0000;
    // Outputs
    logic                   mst_done, own_mem_gnt, usr_irq;
    logic [`HBP_DATA_W-1:0] mst_rdata;
    logic [`HBP_IRQ_W-1:0]  irq_status;
    // Tallies; the cycle ceiling is far above the hundred or so cycles used
    int                     mismatches = 0;
    int                     checked    = 0;
    int                     cycles     = 0;

    always #5 ref_clk = ~ref_clk;

    hbp_if hbp_if_i ();
    hbp_dev hbp_dev_i (.ref_clk(ref_clk), .rst(rst), .bus(hbp_if_i), .mst_start(mst_start),
        .mst_write(mst_write), .mst_addr(mst_addr), .mst_wdata(mst_wdata), .mst_done(mst_done),
        .mst_rdata(mst_rdata), .own_mem_req(own_mem_req), .own_mem_gnt(own_mem_gnt),
        .regs_ready(regs_ready), .irq_set(irq_set), .irq_clr(irq_clr), .irq_mask(irq_mask),
        .irq_status(irq_status));
    hbp_host hbp_host_i (.ref_clk(ref_clk), .rst(rst), .bus(hbp_if_i), .usr_style(usr_style),
        .usr_reg_req(usr_reg_req), .usr_mem_req(usr_mem_req), .usr_grant_ok(usr_grant_ok),
        .usr_ready(usr_ready), .usr_rdata(usr_rdata), .usr_acc_done(), .usr_busy(),
        .usr_irq(usr_irq));
    hbp_link_asserts hbp_link_asserts_i (.ref_clk(ref_clk), .rst(rst),
        .chip_select_n(hbp_if_i.chip_select_n),
        .shared_mem_request_n(hbp_if_i.shared_mem_request_n),
        .slave_access_ack_n(hbp_if_i.slave_access_ack_n),
        .bus_style_select(hbp_if_i.bus_style_select), .bus_request(hbp_if_i.bus_request),
        .bus_grant_in(hbp_if_i.bus_grant_in), .addr_valid_strobe(hbp_if_i.addr_valid_strobe),
        .transfer_direction(hbp_if_i.transfer_direction),
        .data_phase_strobe_n(hbp_if_i.data_phase_strobe_n),
        .wait_ready_in(hbp_if_i.wait_ready_in), .master_oe(hbp_if_i.master_oe),
        .master_addr(hbp_if_i.master_addr), .irq_out(hbp_if_i.irq_out));

    // ============================================================
    // Shared helpers; samples right after an edge see settled pre-edge values
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask : chk

    // Waits for acknowledge low, counting edges
    task wait_ack(output int lat);
        lat = 0;
        while (hbp_if_i.slave_access_ack_n !== 1'h0 && lat < 20)
        begin
            @(posedge ref_clk);
            lat++;
        end
        chk("one owner", 0, own_mem_gnt);
    endtask : wait_ack

    // One master cycle; waits gives data phases held by the host before ending
    task mst_cycle(input logic wr, input logic [31:0] a, input logic [31:0] d, input int waits);
        int n;
        int ds;
        @(posedge ref_clk);
        mst_start <= 1'h1;
        mst_write <= wr;
        mst_addr  <= a;
        mst_wdata <= d;
        usr_ready <= (waits == 0);
        @(posedge ref_clk);
        mst_start <= 1'h0;
        ds = 0;
        for (n = 0; n < 60 && mst_done !== 1'h1; n++)
        begin
            if (hbp_if_i.data_phase_strobe_n === 1'h0)
            begin
                ds++;
                if (ds == waits) usr_ready <= 1'h1;
                chk("direction", wr, hbp_if_i.transfer_direction);
                chk("address", a, hbp_if_i.master_addr);
                if (wr) chk("write data", d, hbp_if_i.master_wdata);
            end
            @(posedge ref_clk);
        end
        chk("done", 1, mst_done);
        chk("wait states", 1, ds > waits);
        chk("request dropped", 0, hbp_if_i.bus_request);
        if (!wr) chk("read data", usr_rdata, mst_rdata);
    endtask : mst_cycle

    // ============================================================
    // Scenarios
    task t_read;
        usr_rdata <= 32'hA5C3_0F96;
        mst_cycle(1'h0, 32'h0000_1234, 32'h0000_0000, 0);
        $display("done t_read");
    endtask : t_read

    task t_write_waits;
        mst_cycle(1'h1, 32'hFFFF_FFFC, 32'h1357_9BDF, 3);
        $display("done t_write_waits");
    endtask : t_write_waits

    task t_grant_late;
        usr_grant_ok <= 1'h0;
        fork
            mst_cycle(1'h1, 32'h0000_0040, 32'h0000_00FF, 0);
            begin
                repeat (8) @(posedge ref_clk);
                chk("request up", 1, hbp_if_i.bus_request);
                chk("no oe", 0, hbp_if_i.master_oe);
                chk("no strobe", 1, hbp_if_i.addr_valid_strobe);
                usr_grant_ok <= 1'h1;
            end
        join
        $display("done t_grant_late");
    endtask : t_grant_late

    task t_reg_then_mem;
        int lat;
        int gap;
        regs_ready  <= 1'h0;
        usr_reg_req <= 1'h1;
        repeat (6) @(posedge ref_clk);
        chk("no ack unready", 1, hbp_if_i.slave_access_ack_n);
        regs_ready <= 1'h1;
        wait_ack(lat);
        chk("reg ack", 1, lat <= 3);
        usr_reg_req <= 1'h0;
        usr_mem_req <= 1'h1;
        for (lat = 0; lat < 20 && hbp_if_i.chip_select_n !== 1'h1; lat++) @(posedge ref_clk);
        for (gap = 0; gap < 20 && hbp_if_i.shared_mem_request_n !== 1'h0; gap++)
            @(posedge ref_clk);
        chk("select gap", 1, gap >= `HBP_SEL_GAP_CLKS);
        wait_ack(lat);
        chk("mem ack", 0, hbp_if_i.slave_access_ack_n);
        usr_mem_req <= 1'h0;
        repeat (4) @(posedge ref_clk);
        chk("ack released", 1, hbp_if_i.slave_access_ack_n);
        $display("done t_reg_then_mem");
    endtask : t_reg_then_mem

    task t_mem_arbiter;
        int lat;
        own_mem_req <= 1'h1;
        for (lat = 0; lat < 20 && own_mem_gnt !== 1'h1; lat++) @(posedge ref_clk);
        usr_mem_req <= 1'h1;
        own_mem_req <= 1'h0;
        wait_ack(lat);
        chk("ack after own use", 1, lat <= 6);
        chk("device off memory", 0, own_mem_gnt);
        usr_mem_req <= 1'h0;
        repeat (4) @(posedge ref_clk);
        $display("done t_mem_arbiter");
    endtask : t_mem_arbiter

    task t_irq;
        irq_set <= 8'h04;
        @(posedge ref_clk);
        irq_set <= 8'h00;
        repeat (3) @(posedge ref_clk);
        chk("status", 8'h04, irq_status);
        chk("masked quiet", 0, hbp_if_i.irq_out);
        irq_mask <= 8'h04;
        repeat (6) @(posedge ref_clk);
        chk("irq level", 1, hbp_if_i.irq_out);
        chk("host irq", 1, usr_irq);
        usr_style <= 1'h1;
        repeat (3) @(posedge ref_clk);
        chk("style quiet", 0, hbp_if_i.irq_out);
        usr_style <= 1'h0;
        irq_set <= 8'h01;
        irq_clr <= 8'h05;
        @(posedge ref_clk);
        irq_set <= 8'h00;
        irq_clr <= 8'h00;
        repeat (3) @(posedge ref_clk);
        chk("set wins", 8'h01, irq_status);
        chk("irq cleared", 0, hbp_if_i.irq_out);
        $display("done t_irq");
    endtask : t_irq

    // ============================================================
    // Verdict, reached from the main sequence or the cycle ceiling
    task results;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    // Cycle ceiling cuts a hang short
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            results();
        end
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        t_read();
        t_write_waits();
        t_grant_late();
        t_reg_then_mem();
        t_mem_arbiter();
        t_irq();
        results();
    end
endmodule : host_bus_master_slave_port_test
